// ---- rtl/dmsi_top.sv ----
// Design decision made here: the Wishbone slave port.
`include "dmsi_params.svh"
// How it works
// [R1] format bit picks async or clocked sync
// [R2] async receiver resyncs on each start bit
// [R3] async formats: 7/8/5 bits, parity, stops
// [R4] extra mp bit marks id versus data
// [R5] parity, overrun, framing flagged separately
// [R6] filtered receive pin level readable by software
// [R7] sync: bit clock, eight bits, overrun only
// [R8] independent transmitter and receiver units
// [R9] holding plus shifter on both paths
// [R10] programmable divider sets the bit rate
// [R11] internal or external serial clock select
// [R12] six interrupt sources in status
// [R13] clock two-way, rxd input, txd output
// [R14] receive lsb first, then to holding
// [R15] transmit from holding only when loaded
// [R16] short characters drop upper data bits
// [R17] parity bit makes ones even or odd
// [R18] low start bit, high idle, stop check
// [R19] overrun when holding still unread
module dmsi_top (
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire dmsi_pkg::dmsi_adr_t  wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [31:0]          wb_dat_i,
  output logic [31:0]               wb_dat_o,
  output logic                      wb_ack_o,
  input  wire logic                 receive_data_pin_i,
  output logic                      transmit_data_pin_o,
  input  wire logic                 serial_clock_pin_i,
  output logic                      serial_clock_pin_o,
  output logic                      serial_clock_pin_oe_o,
  output logic                      irq_o
);
  import dmsi_pkg::*;

  // ==========================================
  // registers
  dmsi_byte_t fmt_reg;  // format and prescale
  dmsi_byte_t brr_reg;  // divider setting
  dmsi_byte_t ctl_reg;  // enables and clock select
  dmsi_byte_t tdr_reg;  // transmit holding
  dmsi_byte_t rdr_reg;  // receive holding
  dmsi_byte_t msk_reg;  // interrupt mask
  dmsi_byte_t stop_reg; // module clock stop
  dmsi_byte_t port_reg; // port control storage
  logic [7:0] sts_reg;  // status flags
  dmsi_byte_t rd_mux;   // read data select

  // ==========================================
  // bus decode
  logic req;    // new access this cycle
  logic wr_lo;  // write with low lane
  logic rd;     // read access
  logic tdr_wr; // transmit holding written
  logic sts_wr; // status written
  logic rdr_rd; // receive holding read

  // address compare on word index
  function automatic logic hit(input dmsi_adr_t a, input logic [15:0] idx);
    hit = (a[17:2] == idx) && (a[1:0] == 2'b00);
  endfunction

  assign req    = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_lo  = req && wb_we_i && wb_sel_i[0];
  assign rd     = req && !wb_we_i;
  assign tdr_wr = wr_lo && hit(wb_adr_i, `DMSI_IDX_TDR);
  assign sts_wr = wr_lo && hit(wb_adr_i, `DMSI_IDX_STS);
  assign rdr_rd = rd && hit(wb_adr_i, `DMSI_IDX_RDR);

  // ==========================================
  // pin synchronisers: three stages, change once stages two and three agree
  logic [1:0] pin_raw; // sck, rxd
  logic [1:0] pin_f;   // filtered levels
  assign pin_raw = {serial_clock_pin_i, receive_data_pin_i};

  generate
    for (genvar g = 0; g < 2; g++) begin : g_sync
      logic [2:0] s; // stage 0 is first
      logic       f; // agreed level
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          s <= 3'b111;
          f <= 1'b1;
        end else begin
          s <= {s[1], s[0], pin_raw[g]};
          if (s[1] == s[2]) begin
            f <= s[2];
          end
        end
      end
      assign pin_f[g] = f;
    end
  endgenerate

  // ==========================================
  // configuration writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fmt_reg  <= `DMSI_RST_FMT;
      brr_reg  <= `DMSI_RST_BRR;
      ctl_reg  <= `DMSI_RST_CTL;
      tdr_reg  <= `DMSI_RST_TDR;
      msk_reg  <= `DMSI_RST_MSK;
      stop_reg <= `DMSI_RST_STOP;
      port_reg <= `DMSI_RST_PORT;
    end else if (wr_lo) begin
      if (hit(wb_adr_i, `DMSI_IDX_FMT)) fmt_reg <= wb_dat_i[7:0]; // R1
      if (hit(wb_adr_i, `DMSI_IDX_BRR)) brr_reg <= wb_dat_i[7:0]; // R10
      if (hit(wb_adr_i, `DMSI_IDX_CTL)) ctl_reg <= wb_dat_i[7:0]; // R11
      if (tdr_wr) tdr_reg <= wb_dat_i[7:0]; // R9
      if (hit(wb_adr_i, `DMSI_IDX_MSK)) msk_reg <= wb_dat_i[7:0];
      if (hit(wb_adr_i, `DMSI_IDX_STOP)) stop_reg <= wb_dat_i[7:0];
      if (hit(wb_adr_i, `DMSI_IDX_PORT)) port_reg <= {wb_dat_i[7:1], 1'b0};
    end
  end

  // ==========================================
  // read mux; port bit 0 shows the receive pin level
  always_comb begin
    rd_mux = 8'h00; // unmapped reads zero
    if (hit(wb_adr_i, `DMSI_IDX_FMT))  rd_mux = fmt_reg;
    if (hit(wb_adr_i, `DMSI_IDX_BRR))  rd_mux = brr_reg;
    if (hit(wb_adr_i, `DMSI_IDX_CTL))  rd_mux = ctl_reg;
    if (hit(wb_adr_i, `DMSI_IDX_TDR))  rd_mux = tdr_reg;
    if (hit(wb_adr_i, `DMSI_IDX_STS))  rd_mux = sts_reg;
    if (hit(wb_adr_i, `DMSI_IDX_RDR))  rd_mux = rdr_reg;
    if (hit(wb_adr_i, `DMSI_IDX_MSK))  rd_mux = msk_reg;
    if (hit(wb_adr_i, `DMSI_IDX_STOP)) rd_mux = stop_reg;
    if (hit(wb_adr_i, `DMSI_IDX_PORT)) rd_mux = {port_reg[7:1], pin_f[0]}; // R6
  end

  // bus answer one cycle after the request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req;
      if (rd) begin
        wb_dat_o <= {24'h00_0000, rd_mux};
      end
    end
  end

  // ==========================================
  // format decode
  logic       sync_m;   // clocked sync mode
  logic       five;     // five bit characters
  logic [3:0] len;      // data bits
  logic       ext_clk;  // clock from pin
  logic       unit_run; // module clock running
  logic       tx_en;    // transmitter enabled
  logic       rx_en;    // receiver enabled

  assign sync_m   = fmt_reg[`DMSI_FMT_COM]; // R1
  assign five     = !sync_m && fmt_reg[`DMSI_FMT_CHR] && fmt_reg[`DMSI_FMT_PE]
                    && fmt_reg[`DMSI_FMT_MP]; // R3
  assign len      = dmsi_data_len(sync_m, fmt_reg[`DMSI_FMT_CHR], five); // R3
  assign ext_clk  = ctl_reg[`DMSI_CTL_CKE1]; // R11
  assign unit_run = stop_reg[`DMSI_STOP_RUN];
  assign tx_en    = ctl_reg[`DMSI_CTL_TE] && unit_run; // R8
  assign rx_en    = ctl_reg[`DMSI_CTL_RE] && unit_run; // R8

  // ==========================================
  // bit rate divider: (setting+1) times 4 to the prescale power
  logic [14:0] div_cnt; // divider count
  logic [14:0] div_lim; // terminal count
  logic        div_stb; // sixteenth of a bit

  assign div_lim = (({7'h00, brr_reg} + 15'h0001) << {fmt_reg[1:0], 1'b0}) - 15'h0001;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_cnt <= 15'h0000;
      div_stb <= 1'b0;
    end else begin
      div_stb <= (div_cnt >= div_lim); // R10
      div_cnt <= (div_cnt >= div_lim) ? 15'h0000 : div_cnt + 15'h0001;
    end
  end

  // ==========================================
  // serial clock: phase of sixteen ticks, low half then high half
  logic [3:0] ph_reg;   // tick phase
  logic       sck_q;    // previous filtered pin clock
  logic       fall_int; // internal falling edge
  logic       rise_int; // internal rising edge
  logic       tx_adv;   // transmitter advance
  logic       rx_adv;   // receiver advance
  logic       os_stb;   // async oversample tick

  assign fall_int = div_stb && ph_reg == 4'hF;
  assign rise_int = div_stb && ph_reg == 4'h7;
  assign os_stb   = ext_clk ? (pin_f[1] && !sck_q) : div_stb; // R11
  assign tx_adv   = !sync_m ? os_stb : (ext_clk ? (!pin_f[1] && sck_q) : fall_int); // R7
  assign rx_adv   = !sync_m ? os_stb : (ext_clk ? (pin_f[1] && !sck_q) : rise_int); // R7

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sck_q <= 1'b1;
    end else begin
      sck_q <= pin_f[1];
    end
  end

  // clock output, idle high while both units are off
  always_ff @(posedge clk_i) begin
    if (rst_i || !(tx_en || rx_en)) begin
      ph_reg             <= 4'h0;
      serial_clock_pin_o <= 1'b1;
    end else if (div_stb) begin
      ph_reg <= ph_reg + 4'h1;
      if (rise_int) serial_clock_pin_o <= 1'b1;
      if (fall_int) serial_clock_pin_o <= 1'b0;
    end
  end

  // pin drive direction
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      serial_clock_pin_oe_o <= 1'b0;
    end else begin
      serial_clock_pin_oe_o <= !ext_clk && (sync_m || ctl_reg[`DMSI_CTL_CKE0]); // R13
    end
  end

  // ==========================================
  // transmitter and receiver units
  logic       tx_take; // holding moved to shifter
  logic       tx_done; // last bit finished
  logic       tx_busy; // shifter in use
  logic       tx_line; // shifter output
  logic       rx_done; // character complete
  dmsi_byte_t rx_data; // received character
  logic       rx_per;  // parity mismatch
  logic       rx_fer;  // stop bit low
  logic       rx_mpb;  // received mp bit
  logic       rx_ok;   // character accepted
  logic       rx_ovr;  // character lost

  dmsi_tx u_tx (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .en_i         (tx_en),
    .sync_i       (sync_m),
    .adv_i        (tx_adv),
    .len_i        (len),
    .par_en_i     (!sync_m && fmt_reg[`DMSI_FMT_PE]),
    .par_odd_i    (fmt_reg[`DMSI_FMT_PM]),
    .mp_en_i      (!sync_m && !five && fmt_reg[`DMSI_FMT_MP]),
    .mp_bit_i     (sts_reg[`DMSI_STS_MPBT]),
    .two_stop_i   (fmt_reg[`DMSI_FMT_STOP]),
    .hold_valid_i (!sts_reg[`DMSI_STS_TRANSMIT_EMPTY_FLAG]),
    .hold_data_i  (tdr_reg),
    .take_o       (tx_take),
    .done_o       (tx_done),
    .busy_o       (tx_busy),
    .txd_o        (tx_line)
  );

  assign transmit_data_pin_o = tx_line; // R13

  dmsi_rx u_rx (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .en_i      (rx_en),
    .sync_i    (sync_m),
    .adv_i     (rx_adv),
    .line_i    (pin_f[0]),
    .len_i     (len),
    .par_en_i  (!sync_m && fmt_reg[`DMSI_FMT_PE]),
    .par_odd_i (fmt_reg[`DMSI_FMT_PM]),
    .mp_en_i   (!sync_m && !five && fmt_reg[`DMSI_FMT_MP]),
    .done_o    (rx_done),
    .data_o    (rx_data),
    .per_o     (rx_per),
    .fer_o     (rx_fer),
    .mpb_o     (rx_mpb)
  );

  // a read in the same cycle frees the holding register
  assign rx_ok  = rx_done && (!sts_reg[`DMSI_STS_RDRF] || rdr_rd); // R14
  assign rx_ovr = rx_done && sts_reg[`DMSI_STS_RDRF] && !rdr_rd; // R19

  // receive holding load
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdr_reg <= `DMSI_RST_RDR;
    end else if (rx_ok) begin
      rdr_reg <= rx_data; // R14
    end
  end

  // ==========================================
  // status flags: set wins over clear
  logic [7:2] sts_set; // event per flag
  logic [7:2] sts_clr; // clear per flag

  assign sts_set = {tx_take, rx_ok, rx_ovr, rx_ok && rx_fer, rx_ok && rx_per,
                    tx_done && sts_reg[`DMSI_STS_TRANSMIT_EMPTY_FLAG]}; // R12
  assign sts_clr = (sts_wr ? (wb_dat_i[7:2] & 6'(`DMSI_STS_W1C >> 2)) : 6'h00)
                   | {tdr_wr, rdr_rd, 3'b000, tdr_wr};

  generate
    for (genvar b = 2; b < 8; b++) begin : g_flag
      localparam logic [7:0] STS_INIT = `DMSI_RST_STS; // reset image of status
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          sts_reg[b] <= STS_INIT[b];
        end else begin
          sts_reg[b] <= sts_set[b] || (sts_reg[b] && !sts_clr[b]); // R5
        end
      end
    end
  endgenerate

  // mp bits: received one tracks each accepted character, send bit by software
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sts_reg[1:0] <= 2'b00;
    end else begin
      if (rx_ok) sts_reg[`DMSI_STS_MPBR] <= rx_mpb; // R4
      if (sts_wr) sts_reg[`DMSI_STS_MPBT] <= wb_dat_i[0];
    end
  end

  // one level interrupt from unmasked flags
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(sts_reg[7:2] & msk_reg[7:2]); // R12
    end
  end

  // ==========================================
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_rx_load: assert property (rx_ok |=> rdr_reg == $past(rx_data) && sts_reg[6]) // R14
    else $error("receive holding not loaded");
  chk_overrun_flag: assert property (rx_ovr |=> sts_reg[5] && $stable(rdr_reg)) // R19
    else $error("overrun not flagged or data lost");
  chk_take_sets: assert property (tx_take |=> sts_reg[7]) // R15
    else $error("empty flag not set after take");
  chk_take_needs_data: assert property (tx_take |-> $past(!sts_reg[7])) // R15
    else $error("transfer with no new data");
  chk_sync_errors: assert property (sync_m && rx_done |-> !rx_per && !rx_fer) // R7
    else $error("error flagged in sync mode");
  chk_fer_flag: assert property (rx_ok && rx_fer |=> sts_reg[4]) // R5
    else $error("framing error lost");
  chk_per_flag: assert property (rx_ok && rx_per |=> sts_reg[3]) // R17
    else $error("parity error lost");
  chk_idle_high: assert property (!tx_busy && !sync_m |-> transmit_data_pin_o) // R18
    else $error("line not idle high");
  chk_ext_clk_dir: assert property (ext_clk |=> !serial_clock_pin_oe_o) // R13
    else $error("driving clock pin in external mode");
  chk_irq_cause: assert property ($rose(irq_o) |-> $past(|(sts_reg[7:2] & msk_reg[7:2]))) // R12
    else $error("interrupt with no cause");

  cov_tx_take: cover property (tx_take);
  cov_rx_ok: cover property (rx_ok);
  cov_rx_ovr: cover property (rx_ovr);
  cov_sync_rx: cover property (sync_m && rx_done);
endmodule // dmsi_top

// ---- rtl/dmsi_params.svh ----
`ifndef DMSI_PARAMS_SVH
`define DMSI_PARAMS_SVH
// ==========================================
// register indices, byte address is four times the index
`define DMSI_IDX_PORT 16'hFF91
`define DMSI_IDX_FMT  16'hFFA8
`define DMSI_IDX_BRR  16'hFFA9
`define DMSI_IDX_CTL  16'hFFAA
`define DMSI_IDX_TDR  16'hFFAB
`define DMSI_IDX_STS  16'hFFAC
`define DMSI_IDX_RDR  16'hFFAD
`define DMSI_IDX_MSK  16'hFFAE
`define DMSI_IDX_STOP 16'hFFFA
// ==========================================
// reset values
`define DMSI_RST_FMT  8'h00
`define DMSI_RST_BRR  8'hFF
`define DMSI_RST_CTL  8'h00
`define DMSI_RST_TDR  8'hFF
`define DMSI_RST_STS  8'h84
`define DMSI_RST_RDR  8'h00
`define DMSI_RST_MSK  8'h00
`define DMSI_RST_STOP 8'hFF
`define DMSI_RST_PORT 8'h00
// ==========================================
// field positions
`define DMSI_FMT_COM  7
`define DMSI_FMT_CHR  6
`define DMSI_FMT_PE   5
`define DMSI_FMT_PM   4
`define DMSI_FMT_STOP 3
`define DMSI_FMT_MP   2
`define DMSI_CTL_TE   5
`define DMSI_CTL_RE   4
`define DMSI_CTL_CKE1 1
`define DMSI_CTL_CKE0 0
`define DMSI_STS_TRANSMIT_EMPTY_FLAG 7
`define DMSI_STS_RDRF 6
`define DMSI_STS_OER  5
`define DMSI_STS_FER  4
`define DMSI_STS_PER  3
`define DMSI_STS_TEND 2
`define DMSI_STS_MPBR 1
`define DMSI_STS_MPBT 0
`define DMSI_STS_W1C  8'h7C
`define DMSI_STOP_RUN 6
// ==========================================
// timing: sixteen ticks per asynchronous bit
`define DMSI_SUB_LAST 4'hF
`define DMSI_SUB_MID  4'h7
`define DMSI_SYNC_LEN 4'h8
`endif

// ---- rtl/dmsi_pkg.sv ----
package dmsi_pkg;
  // ==========================================
  // shared types
  typedef logic [7:0]  dmsi_byte_t;
  typedef logic [17:0] dmsi_adr_t;
  typedef enum logic {DMSI_RX_IDLE, DMSI_RX_RUN} dmsi_rx_state_e;

  // data bits per character for a format
  function automatic logic [3:0] dmsi_data_len(input logic sync, input logic chr,
                                               input logic five);
    dmsi_data_len = sync ? 4'h8 : (five ? 4'h5 : (chr ? 4'h7 : 4'h8));
  endfunction
endpackage

// ---- rtl/dmsi_tx.sv ----
`include "dmsi_params.svh"
module dmsi_tx (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              en_i,
  input  wire logic              sync_i,
  input  wire logic              adv_i,
  input  wire logic [3:0]        len_i,
  input  wire logic              par_en_i,
  input  wire logic              par_odd_i,
  input  wire logic              mp_en_i,
  input  wire logic              mp_bit_i,
  input  wire logic              two_stop_i,
  input  wire logic              hold_valid_i,
  input  wire dmsi_pkg::dmsi_byte_t hold_data_i,
  output logic                   take_o,
  output logic                   done_o,
  output logic                   busy_o,
  output logic                   txd_o
);
  import dmsi_pkg::*;

  logic [11:0] sh_reg;   // frame shifter, lsb on the line
  logic [3:0]  left_reg; // bits still to send
  logic [3:0]  sub_reg;  // tick within a bit
  logic [11:0] fr;       // frame built from the holding byte
  logic [3:0]  cnt;      // frame length in bits
  logic [7:0]  dm;       // data with unsent bits removed

  // ==========================================
  // frame assembly: start, data lsb first, parity, mp bit, stops
  always_comb begin
    fr  = 12'hFFF;
    dm  = hold_data_i & (8'hFF >> (4'h8 - len_i)); // R16
    cnt = `DMSI_SYNC_LEN;
    if (sync_i) begin
      fr[7:0] = hold_data_i; // R7
    end else begin
      fr[0]   = 1'b0; // R18
      fr[8:1] = (8'hFF << len_i) | dm; // R16
      fr[len_i + 4'h1] = par_en_i ? (^dm ^ par_odd_i) : mp_bit_i; // R17
      if (par_en_i) begin
        fr[len_i + 4'h2] = mp_en_i ? mp_bit_i : 1'b1; // R4
      end
      cnt = len_i + 4'h2 + {3'b000, par_en_i} + {3'b000, mp_en_i} + {3'b000, two_stop_i}; // R3
    end
    if (!par_en_i && !mp_en_i && !sync_i) begin
      fr[len_i + 4'h1] = 1'b1;
    end
  end

  // ==========================================
  // shifter: loads from holding only when empty, shifts per bit
  always_ff @(posedge clk_i) begin
    if (rst_i || !en_i) begin
      sh_reg   <= 12'hFFF;
      left_reg <= 4'h0;
      sub_reg  <= 4'h0;
      take_o   <= 1'b0;
      done_o   <= 1'b0;
    end else begin
      take_o <= 1'b0;
      done_o <= 1'b0;
      if (left_reg == 4'h0) begin
        // no load while holding is empty
        if (hold_valid_i && !take_o && (!sync_i || adv_i)) begin // R15
          sh_reg   <= fr;
          left_reg <= cnt;
          sub_reg  <= 4'h0;
          take_o   <= 1'b1; // R9
        end
      end else if (adv_i) begin
        sub_reg <= sub_reg + 4'h1;
        if (sync_i || sub_reg == `DMSI_SUB_LAST) begin
          sh_reg   <= {1'b1, sh_reg[11:1]}; // R15
          left_reg <= left_reg - 4'h1;
          sub_reg  <= 4'h0;
          done_o   <= (left_reg == 4'h1);
        end
      end
    end
  end

  assign busy_o = (left_reg != 4'h0);
  assign txd_o  = sh_reg[0];
endmodule // dmsi_tx

// ---- rtl/dmsi_rx.sv ----
`include "dmsi_params.svh"
module dmsi_rx (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       en_i,
  input  wire logic       sync_i,
  input  wire logic       adv_i,
  input  wire logic       line_i,
  input  wire logic [3:0] len_i,
  input  wire logic       par_en_i,
  input  wire logic       par_odd_i,
  input  wire logic       mp_en_i,
  output logic            done_o,
  output dmsi_pkg::dmsi_byte_t data_o,
  output logic            per_o,
  output logic            fer_o,
  output logic            mpb_o
);
  import dmsi_pkg::*;

  dmsi_rx_state_e st_reg; // idle or in a frame
  logic [11:0] sh_reg;    // sampled bits by position
  logic [3:0]  idx_reg;   // position of next sample
  logic [3:0]  sub_reg;   // tick within a bit
  logic [11:0] fr;        // frame including current sample
  logic [3:0]  last;      // position of first stop bit, last data bit in sync
  logic [7:0]  dm;        // masked data
  logic        smp;       // sample strobe

  // async samples mid bit, sync on every bit clock
  assign smp  = sync_i ? adv_i : (adv_i && sub_reg == `DMSI_SUB_MID); // R2
  assign last = sync_i ? `DMSI_SYNC_LEN
                       : len_i + 4'h1 + {3'b000, par_en_i} + {3'b000, mp_en_i};

  // ==========================================
  // frame view with the bit being sampled now
  always_comb begin
    fr          = sh_reg;
    fr[idx_reg] = line_i;
    dm          = fr[8:1] & (8'hFF >> (4'h8 - len_i)); // R14
  end

  // ==========================================
  // sequencer: start search, per character resync
  always_ff @(posedge clk_i) begin
    if (rst_i || !en_i) begin
      st_reg  <= DMSI_RX_IDLE;
      idx_reg <= 4'h0;
      sub_reg <= 4'h0;
      sh_reg  <= 12'h000;
    end else begin
      unique case (st_reg)
        DMSI_RX_IDLE: begin
          if (sync_i) begin
            st_reg  <= DMSI_RX_RUN;
            idx_reg <= 4'h1;
          end else if (adv_i && !line_i) begin // R2
            st_reg  <= DMSI_RX_RUN;
            idx_reg <= 4'h0;
            sub_reg <= 4'h0;
          end
        end
        DMSI_RX_RUN: begin
          if (adv_i) begin
            sub_reg <= sub_reg + 4'h1;
          end
          if (smp) begin
            sh_reg[idx_reg] <= line_i; // R14
            idx_reg         <= idx_reg + 4'h1;
            if (!sync_i && idx_reg == 4'h0 && line_i) begin
              st_reg <= DMSI_RX_IDLE; // false start
            end else if (idx_reg == last) begin
              st_reg  <= sync_i ? DMSI_RX_RUN : DMSI_RX_IDLE;
              idx_reg <= 4'h1;
            end
          end
        end
      endcase
    end
  end

  // ==========================================
  // result capture at the last sample
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      done_o <= 1'b0;
      data_o <= 8'h00;
      per_o  <= 1'b0;
      fer_o  <= 1'b0;
      mpb_o  <= 1'b0;
    end else begin
      done_o <= en_i && st_reg == DMSI_RX_RUN && smp && idx_reg == last;
      if (en_i && st_reg == DMSI_RX_RUN && smp && idx_reg == last) begin
        data_o <= dm;
        per_o  <= !sync_i && par_en_i && (^dm ^ fr[len_i + 4'h1] ^ par_odd_i); // R17
        fer_o  <= !sync_i && !line_i; // R18
        mpb_o  <= !sync_i && mp_en_i && fr[len_i + 4'h1 + {3'b000, par_en_i}]; // R4
      end
    end
  end
endmodule // dmsi_rx

// ---- tb/dmsi_far_end.sv ----
// far-end async serial chip, sixteen cycles a bit
module dmsi_far_end (
  input  wire logic clk_i,
  input  wire logic txd_i,
  output logic      rxd_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [11:0] got;  // last frame seen on the transmit pin
  int          ngot; // frames seen so far
  initial rxd_o = 1'b1;
  // drive one frame lsb first; padding bits are idle high
  task automatic send(input logic [11:0] f);
    for (int i = 0; i < 12; i++) begin
      rxd_o <= f[i];
      repeat (16) @(posedge clk_i);
    end
  endtask
  // capture twelve mid-bit samples after each start edge
  initial begin
    ngot = 0;
    forever begin
      @(negedge txd_i);
      repeat (8) @(posedge clk_i);
      for (int i = 0; i < 12; i++) begin
        got[i] = txd_i;
        repeat (16) @(posedge clk_i);
      end
      ngot++;
    end
  end
endmodule // dmsi_far_end

// ---- tb/test_dual_mode_serial_interface.sv ----
`include "dmsi_params.svh"
module test_dual_mode_serial_interface;
  import dmsi_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ack, rxd, txd, irq;
  dmsi_adr_t   adr = '0;
  logic [31:0] dat = '0, dat_o;
  dmsi_byte_t  q, d;
  int          error_cnt = 0, n_checks = 0;
  logic [15:0] ia [10] = '{`DMSI_IDX_FMT, `DMSI_IDX_BRR, `DMSI_IDX_CTL, `DMSI_IDX_TDR,
    `DMSI_IDX_STS, `DMSI_IDX_RDR, `DMSI_IDX_MSK, `DMSI_IDX_STOP, `DMSI_IDX_PORT, 16'hFFB0};
  dmsi_byte_t  ea [10] = '{8'h00, 8'hFF, 8'h00, 8'hFF, 8'h84, 8'h00, 8'h00, 8'hFF, 8'h01, 8'h00};
  dmsi_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .receive_data_pin_i(rxd), .transmit_data_pin_o(txd), .serial_clock_pin_i(1'b1),
    .serial_clock_pin_o(), .serial_clock_pin_oe_o(), .irq_o(irq));
  dmsi_far_end far (.clk_i(clk_i), .txd_i(txd), .rxd_o(rxd));
  initial forever #5 clk_i = ~clk_i;
  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one classic bus cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [15:0] i, input dmsi_byte_t v);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {i, 2'b00};
    dat <= {24'h0, v};
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    q = dat_o[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  // expected line bits: start, data lsb first, parity, mp bit, idle high
  function automatic logic [11:0] frame(input dmsi_byte_t f, input dmsi_byte_t v);
    int n, p;
    logic par;
    frame = 12'hFFE;
    n = (f[6] & f[5] & f[2]) ? 5 : (f[6] ? 7 : 8);
    par = f[4];
    p = 1;
    for (int i = 0; i < n; i++) begin
      frame[p] = v[i];
      par ^= v[i];
      p++;
    end
    if (f[5]) frame[p++] = par;
    if (f[2] && n != 5) frame[p] = 1'b0;
  endfunction
  task automatic tx(input dmsi_byte_t f, input dmsi_byte_t v);
    int n;
    wb(1'b1, `DMSI_IDX_FMT, f);
    n = far.ngot;
    wb(1'b1, `DMSI_IDX_TDR, v);
    for (int t = 0; t < 400 && far.ngot == n; t++) @(posedge clk_i);
    chk(far.got, frame(f, v));
    repeat (40) @(posedge clk_i);
    wb(1'b0, `DMSI_IDX_STS, 8'h00);
    chk(q & 8'h84, 8'h84);
  endtask
  task automatic rx(input logic [11:0] fr, input dmsi_byte_t m, input dmsi_byte_t e);
    far.send(fr);
    repeat (4) @(posedge clk_i);
    wb(1'b0, `DMSI_IDX_STS, 8'h00);
    chk(q & m, e);
  endtask
  task automatic irq_is(input logic e);
    repeat (2) @(posedge clk_i);
    chk(irq, e);
  endtask
  task automatic print_verdict();
    $display("checks=%0d errors=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // watchdog
  initial begin
    repeat (30000) @(posedge clk_i);
    error_cnt++;
    print_verdict();
  end
  initial begin
    void'($urandom(32'h65b9e383));
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    foreach (ia[k]) begin
      wb(1'b0, ia[k], 8'h00);
      chk(q, ea[k]);
    end
    wb(1'b1, `DMSI_IDX_BRR, 8'h00);
    wb(1'b1, `DMSI_IDX_MSK, 8'h78);
    wb(1'b1, `DMSI_IDX_CTL, 8'h30);
    tx(8'h64, 8'($urandom));
    tx(8'h24, 8'($urandom));
    repeat (4) tx({1'b0, 4'($urandom), 3'b000}, 8'($urandom));
    wb(1'b1, `DMSI_IDX_FMT, 8'h20);
    d = 8'($urandom);
    rx(frame(8'h20, d), 8'h78, 8'h40);
    irq_is(1'b1);
    wb(1'b0, `DMSI_IDX_RDR, 8'h00);
    chk(q, d);
    irq_is(1'b0);
    far.send(frame(8'h20, d));
    rx(frame(8'h20, ~d), 8'h78, 8'h60);
    wb(1'b0, `DMSI_IDX_RDR, 8'h00);
    chk(q, d);
    wb(1'b1, `DMSI_IDX_STS, 8'h78);
    irq_is(1'b0);
    rx(frame(8'h20, d) ^ 12'h200, 8'h08, 8'h08);
    wb(1'b0, `DMSI_IDX_RDR, 8'h00);
    chk(q, d);
    rx(frame(8'h20, d) ^ 12'h400, 8'h10, 8'h10);
    irq_is(1'b1);
    wb(1'b1, `DMSI_IDX_MSK, 8'h00);
    irq_is(1'b0);
    print_verdict();
  end
endmodule // test_dual_mode_serial_interface
